// File: common/cfs_pkg.sv
// cpu frequency select register block: shared constants.
// assumes a byte-wide register port fed by an outside smbus engine.
package cfs_pkg;

  // ==========================================================
  // byte addresses
  localparam logic [7:0] ADDR_MULT = 8'h0d;
  localparam logic [7:0] ADDR_DIV = 8'h0e;
  localparam logic [7:0] ADDR_STRAP = 8'h0f;
  localparam logic [7:0] ADDR_TEST_A = 8'h10;
  localparam logic [7:0] ADDR_TEST_B = 8'h11;
  localparam logic [7:0] ADDR_RSEL = 8'h12;

  // ==========================================================
  // field positions
  localparam int DIV_EN_BIT = 7;
  localparam int BYPASS_BIT = 7;
  localparam int STRAP_LSB = 3;

  // ==========================================================
  // reset values
  localparam logic [7:0] MULT_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [2:0] STRAP_TEST_RST = 3'h3;
  localparam logic [7:0] VTEST_RST = 8'h00;
  localparam logic [7:0] RSEL_RST = 8'h00;
  localparam logic [4:0] STRAP_RST = 5'h00;

  // ==========================================================
  // pll gear constant in units of 1e-5 mhz, rates in 0.1 mhz
  localparam logic [22:0] GEAR_E5 = 23'h4940e5;
  localparam logic [7:0] FREQ_OFS = 8'h03;
  localparam logic [13:0] E5_PER_TENTH = 14'h2710;

  // ==========================================================
  // post-load pipeline depth: write edge to load pulse
  localparam int LOAD_LAT = 2;

endpackage : cfs_pkg

// File: src/cfs_regs.sv
// cpu frequency select registers with the rate lookup table.
// assumes a byte port from an smbus engine that strobes whole bytes
// only, straps stable around reset release, and a 25 mhz clk.
`timescale 1ns/1ps

// Operation
// - bit 7 of divisor byte enables programmable cpu rate, resets to 0.
// - when enabled, cpu rate comes from multiplier n and divisor m.
// - every write of the divisor byte starts loading a new cpu rate.
// - bypass clear: group ratio follows latched rate straps.
// - bypass set: group ratio follows software select field.
// - strap byte bits 7..3 show latched straps, read only.
// - each 5-bit code maps to fixed cpu, mid and pci rates.
// - every code uses one pll gear constant fed to the computation.
// - programmed cpu rate equals gear times (n+3) over (m+3).
// - disabled: all rates from straps or select field per bypass.
module cfs_regs
  import cfs_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [4:0] rateStraps,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic [15:0] cpuRate,
  output logic [11:0] midRate,
  output logic [11:0] pciRate,
  output logic [22:0] gearConst,
  output logic freqLoad
);

  // ==========================================================
  // rate lookup: {cpu, mid group, pci} in 0.1 mhz
  function automatic logic [35:0] rateLookup(input logic [4:0] code);
    case (code)
      5'h00: rateLookup = 36'h7d029a14d;
      5'h01: rateLookup = 36'h76c2f817c;
      5'h02: rateLookup = 36'h7082d0168;
      5'h03: rateLookup = 36'h6a42a8154;
      5'h04: rateLookup = 36'h67c29814c;
      5'h05: rateLookup = 36'h640280140;
      5'h06: rateLookup = 36'h5dc2ee177;
      5'h07: rateLookup = 36'h5aa2d516b;
      5'h08: rateLookup = 36'h5782bc15e;
      5'h09: rateLookup = 36'h5502a8154;
      5'h0a: rateLookup = 36'h51428a145;
      5'h0b: rateLookup = 36'h4d826c136;
      5'h0c: rateLookup = 36'h29a29a14d;
      5'h0d: rateLookup = 36'h3e829a14d;
      5'h0e: rateLookup = 36'h49c313189;
      5'h0f: rateLookup = 36'h53529a14d;
      5'h10: rateLookup = 36'h29c29c14e;
      5'h11: rateLookup = 36'h3ea29c14e;
      5'h12: rateLookup = 36'h47e2ff17f;
      5'h13: rateLookup = 36'h53829c14e;
      5'h14: rateLookup = 36'h29c29c14e;
      5'h15: rateLookup = 36'h3ea29c14e;
      5'h16: rateLookup = 36'h44c2dd16f;
      5'h17: rateLookup = 36'h53829c14e;
      5'h18: rateLookup = 36'h41a2bc15e;
      5'h19: rateLookup = 36'h38425812c;
      5'h1a: rateLookup = 36'h35223711b;
      5'h1b: rateLookup = 36'h30c30c186;
      5'h1c: rateLookup = 36'h29a29a14d;
      5'h1d: rateLookup = 36'h3e829a14d;
      5'h1e: rateLookup = 36'h2ee2ee177;
      5'h1f: rateLookup = 36'h53529a14d;
      default: rateLookup = 36'h7d029a14d;
    endcase
  endfunction

  // ==========================================================
  // storage
  logic [7:0] mult_q;
  logic [7:0] div_q;
  logic [2:0] strapTest_q;
  logic [7:0] rsel_q;
  logic [4:0] latched_q;
  logic caught_q;
  logic loadReq_q;
  logic [15:0] progFreq_q;
  logic [7:0] vtest_q [2];

  // ==========================================================
  // decode of the byte port
  logic wrMult;
  logic wrDiv;
  logic wrStrap;
  logic wrRsel;
  logic progEn;
  logic bypass;
  assign wrMult = regWrEn && (regAddr == ADDR_MULT);
  assign wrDiv = regWrEn && (regAddr == ADDR_DIV);
  assign wrStrap = regWrEn && (regAddr == ADDR_STRAP);
  assign wrRsel = regWrEn && (regAddr == ADDR_RSEL);
  assign progEn = div_q[DIV_EN_BIT];
  assign bypass = rsel_q[BYPASS_BIT];

  // ==========================================================
  // rate source selection
  logic [4:0] rateCode;
  logic [35:0] rateEntry;
  assign rateCode = bypass ? rsel_q[4:0] : latched_q;
  assign rateEntry = rateLookup(rateCode);

  // ==========================================================
  // programmed rate: gear*(n+3)/(m+3), scaled to 0.1 mhz
  // one wide divider; area traded for a result in one cycle
  logic [8:0] nPlus;
  logic [7:0] mPlus;
  logic [31:0] progNum;
  logic [31:0] progDen;
  logic [31:0] progQuot;
  logic [15:0] progCalc;
  assign nPlus = {1'b0, mult_q} + {1'b0, FREQ_OFS};
  assign mPlus = {1'b0, div_q[6:0]} + FREQ_OFS;
  assign progNum = 32'(GEAR_E5) * 32'(nPlus);
  assign progDen = 32'(mPlus) * 32'(E5_PER_TENTH);
  assign progQuot = progNum / progDen;
  assign progCalc = progQuot[15:0];

  // ==========================================================
  // read mux; unmapped addresses read zero
  logic [7:0] rdMux;
  always_comb begin
    case (regAddr)
      ADDR_MULT: rdMux = mult_q;
      ADDR_DIV: rdMux = div_q;
      ADDR_STRAP: rdMux = {latched_q, strapTest_q};
      ADDR_TEST_A: rdMux = vtest_q[0];
      ADDR_TEST_B: rdMux = vtest_q[1];
      ADDR_RSEL: rdMux = rsel_q;
      default: rdMux = 8'h00;
    endcase
  end

  // ==========================================================
  // multiplier, divisor and select bytes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mult_q <= MULT_RST;
      div_q <= DIV_RST;
      rsel_q <= RSEL_RST;
    end else begin
      if (wrMult) begin
        mult_q <= regWrData;
      end
      if (wrDiv) begin
        div_q <= regWrData;
      end
      if (wrRsel) begin
        rsel_q <= regWrData;
      end
    end
  end

  // ==========================================================
  // strap byte: straps caught once after reset release; writes
  // only reach the low test bits, the strap copy ignores them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      latched_q <= STRAP_RST;
      caught_q <= 1'b0;
      strapTest_q <= STRAP_TEST_RST;
    end else begin
      if (!caught_q) begin
        latched_q <= rateStraps;
        caught_q <= 1'b1;
      end
      if (wrStrap) begin
        strapTest_q <= regWrData[2:0];
      end
    end
  end

  // ==========================================================
  // vendor test bytes, plain storage
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_vtest
      logic wrHit;
      assign wrHit = regWrEn && (regAddr == (ADDR_TEST_A + 8'(gi)));
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          vtest_q[gi] <= VTEST_RST;
        end else if (wrHit) begin
          vtest_q[gi] <= regWrData;
        end
      end
    end
  endgenerate

  // ==========================================================
  // frequency load: the port strobes only whole bytes, so the
  // request is raised on the same edge the divisor byte lands
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      loadReq_q <= 1'b0;
      progFreq_q <= 16'h0000;
      freqLoad <= 1'b0;
    end else begin
      loadReq_q <= wrDiv;
      freqLoad <= loadReq_q;
      if (loadReq_q) begin
        progFreq_q <= progCalc;
      end
    end
  end

  // ==========================================================
  // output registers; mid and pci always follow the ratio code
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cpuRate <= 16'h0000;
      midRate <= 12'h000;
      pciRate <= 12'h000;
      gearConst <= 23'h000000;
      regRdData <= 8'h00;
    end else begin
      cpuRate <= progEn ? progFreq_q : {4'h0, rateEntry[35:24]};
      midRate <= rateEntry[23:12];
      pciRate <= rateEntry[11:0];
      gearConst <= GEAR_E5;
      regRdData <= rdMux;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic [35:0] strapEntry;
  logic [35:0] selEntry;
  assign strapEntry = rateLookup(latched_q);
  assign selEntry = rateLookup(rsel_q[4:0]);

  chk_enable_bit_write: assert property (
    wrDiv |=> (progEn == $past(regWrData[DIV_EN_BIT])))
    else $error("enable bit not taken from divisor byte");

  chk_load_after_div: assert property (
    wrDiv |-> ##2 freqLoad)
    else $error("divisor write gave no load pulse");

  chk_load_has_cause: assert property (
    freqLoad |-> $past(wrDiv, 2))
    else $error("load pulse without a divisor byte");

  chk_prog_rate_out: assert property (
    (freqLoad && progEn) ##1 progEn |-> cpuRate == $past(progFreq_q))
    else $error("cpu rate does not follow programmed value");

  chk_strap_source: assert property (
    (!bypass && !progEn) |=> (cpuRate[11:0] == $past(strapEntry[35:24]))
      && (midRate == $past(strapEntry[23:12])))
    else $error("rates not taken from latched straps");

  chk_sel_source: assert property (
    bypass |=> (pciRate == $past(selEntry[11:0]))
      && (midRate == $past(selEntry[23:12])))
    else $error("rates not taken from select field");

  chk_strap_readonly: assert property (
    (caught_q && wrStrap) |=> $stable(latched_q))
    else $error("strap copy changed by a write");

  chk_gear_const: assert property (
    caught_q |-> gearConst == GEAR_E5)
    else $error("gear constant wrong");

  chk_table_code2: assert property (
    (rateCode == 5'h02 && !progEn) |=> (cpuRate == 16'h0708)
      && (midRate == 12'h2d0) && (pciRate == 12'h168))
    else $error("code 2 rates wrong");

endmodule // cfs_regs

// File: bench/cfs_host_model.sv
// far-side byte host model: issues whole-byte writes and plain reads.
// assumes the register block samples its port on the rising clk edge.
`timescale 1ns/1ps
module cfs_host_model (
  input wire logic clk,
  input wire logic [7:0] regRdData,
  output logic [7:0] regAddr,
  output logic regWrEn,
  output logic [7:0] regWrData
);
  // ==========================================================
  // idle bus at time zero
  initial begin
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
  end

  // ==========================================================
  // one strobe per complete byte, held across the sampling edge
  task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    #2;
    regAddr = addr;
    regWrData = data;
    regWrEn = 1'b1;
    @(posedge clk);
    #2;
    regWrEn = 1'b0;
    regWrData = ~data; // released data never shows the stale byte
  endtask

  // read data is registered, so it is taken one edge after the address
  task automatic read_byte(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk);
    #2;
    regAddr = addr;
    @(posedge clk);
    #2;
    data = regRdData;
  endtask
endmodule // cfs_host_model

// File: bench/tb_top.sv
// self-checking bench for the cpu frequency select registers.
// assumes cfs_host_model as the far-side byte writer; straps 5'h03 at first
// reset, moved to 5'h1c later so the latched copy can be told from the pins.
`timescale 1ns/1ps
module tb_top
  import cfs_pkg::*;
;
  logic clk;
  logic rstn;
  logic [4:0] rateStraps;
  logic [7:0] regAddr;
  logic regWrEn;
  logic [7:0] regWrData;
  logic [7:0] regRdData;
  logic [15:0] cpuRate;
  logic [11:0] midRate;
  logic [11:0] pciRate;
  logic [22:0] gearConst;
  logic freqLoad;
  logic [7:0] rd;
  int n_fail = 0;
  int check_count = 0;

  // ==========================================================
  // instances
  cfs_regs u_dut (.clk(clk), .rstn(rstn), .rateStraps(rateStraps), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData), .cpuRate(cpuRate),
    .midRate(midRate), .pciRate(pciRate), .gearConst(gearConst), .freqLoad(freqLoad));
  cfs_host_model u_host (.clk(clk), .regRdData(regRdData), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData));

  // ==========================================================
  // shared helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // table rates land one edge after the select write is taken; the wait covers two edges
  task automatic rates(input logic [15:0] c, input logic [11:0] m, input logic [11:0] p);
    repeat (2) @(posedge clk);
    #2;
    check(cpuRate, c);
    check(midRate, m);
    check(pciRate, p);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic test_reset;
    logic [7:0] addrs [6];
    addrs = '{8'h0d, 8'h0e, 8'h10, 8'h11, 8'h12, 8'h20};
    u_host.read_byte(8'h0f, rd);
    check(rd, 8'h1b);
    foreach (addrs[i]) begin
      u_host.read_byte(addrs[i], rd);
      check(rd, 8'h00);
    end
    check(gearConst, 23'h4940e5);
    rates(16'h06a4, 12'h2a8, 12'h154);
    $display("test reset done");
  endtask

  task automatic test_strap_ro;
    u_host.write_byte(8'h0f, 8'he3);
    rateStraps = 5'h1c; // pins move after the catch; the copy must not follow
    u_host.read_byte(8'h0f, rd);
    check(rd, 8'h1b);
    u_host.write_byte(8'h10, 8'h00);
    u_host.write_byte(8'h11, 8'h00);
    u_host.read_byte(8'h11, rd);
    check(rd, 8'h00);
    $display("test strap done");
  endtask

  task automatic test_bypass;
    u_host.write_byte(8'h12, 8'h82);
    rates(16'h0708, 12'h2d0, 12'h168);
    u_host.write_byte(8'h12, 8'h06);
    rates(16'h06a4, 12'h2a8, 12'h154);
    u_host.write_byte(8'h12, 8'h85);
    rates(16'h0640, 12'h280, 12'h140);
    $display("test bypass done");
  endtask

  task automatic test_prog;
    u_host.write_byte(8'h0d, 8'h61);
    u_host.write_byte(8'h0e, 8'hdd);
    check(freqLoad, 1'b0);
    @(posedge clk);
    #2;
    check(freqLoad, 1'b1);
    @(posedge clk);
    #2;
    check(freqLoad, 1'b0);
    check(cpuRate, 16'h01f4);
    check(midRate, 12'h280);
    // a multiplier write alone must not start a load
    u_host.write_byte(8'h0d, 8'hf5);
    repeat (3) begin
      @(posedge clk);
      #2;
      check(freqLoad, 1'b0);
    end
    check(cpuRate, 16'h01f4);
    u_host.write_byte(8'h0e, 8'had);
    rates(16'h09b0, 12'h280, 12'h140);
    @(posedge clk);
    #2;
    check(cpuRate, 16'h09b0);
    u_host.write_byte(8'h0e, 8'h2d);
    repeat (3) @(posedge clk);
    #2;
    check(cpuRate, 16'h0640);
    u_host.read_byte(8'h0e, rd);
    check(rd, 8'h2d);
    $display("test prog done");
  endtask

  // mid-run reset: straps caught again, enable bit back to off
  task automatic test_rereset;
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    #2;
    rstn = 1'b1;
    u_host.read_byte(8'h0f, rd);
    check(rd, 8'he3);
    u_host.read_byte(8'h0e, rd);
    check(rd, 8'h00);
    rates(16'h029a, 12'h29a, 12'h14d);
    $display("test rereset done");
  endtask

  // ==========================================================
  // clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // whole run is under a hundred cycles; 2000 is ample margin
  initial begin
    #(40 * 2000);
    n_fail++;
    report_and_stop();
  end

  initial begin
    rstn = 1'b0;
    rateStraps = 5'h03;
    repeat (8) @(posedge clk);
    #2;
    rstn = 1'b1;
    test_reset();
    test_strap_ro();
    test_bypass();
    test_prog();
    test_rereset();
    report_and_stop();
  end
endmodule // tb_top
